// [rtl/dcfd_top.sv]
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Source field picks start-up clock
// - Switch mode field gates switching, monitor
// - Single-shot bit allows one remap only
// - Pin function bit: clock out or GPIO outside crystal modes
// - Primary mode: off, high, low speed
// - Watchdog enable: software, active-only, off
// - Window disable bit selects window mode
// - Lock wait bit enables PLL lock
// - Prescaler divides by 128 or 32
// - Postscaler divides by two to field
// - Reset loads active partition words, boot word from one fixed address
// - Soft swap keeps current configuration
// - Lock bit freezes clock when mode allows
module dcfd_top #(
    parameter logic [23:0] PART_B_OFS = 24'h400000
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Nonvolatile memory read port
    output logic nvm_rd_o,
    output logic [23:0] nvm_addr_o,
    input wire logic [23:0] nvm_data_i,
    // Partition control
    input wire logic active_partition_i,
    input wire logic soft_swap_i,
    // Runtime inputs
    input wire logic sleep_i,
    input wire logic remap_write_i,
    // Register port
    input wire logic [23:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Decoded settings
    output dcfd_pkg::dcfd_cfg_t cfg_o,
    output logic cfg_valid_o,
    output logic wdt_run_o,
    output logic remap_permit_o,
    output logic clk_cfg_locked_o
);

    dcfd_pkg::dcfd_state_t st_ff;
    dcfd_pkg::dcfd_state_t nxt_st;

    // Address of each word in the active partition; the boot word has one fixed address
    function automatic logic [23:0] word_addr(input logic [2:0] idx, input logic part);
        logic [23:0] base;
        logic [23:0] ofs;
        base = part ? PART_B_OFS : 24'h000000;
        case (idx)
            dcfd_pkg::W_DEVOPT: ofs = dcfd_pkg::OFS_DEVOPT + base;
            dcfd_pkg::W_ALTREG: ofs = dcfd_pkg::OFS_ALTREG + base;
            dcfd_pkg::W_BTSEQ: ofs = dcfd_pkg::OFS_BTSEQ + base;
            dcfd_pkg::W_BOOT: ofs = dcfd_pkg::OFS_BOOT;
            dcfd_pkg::W_OSC: ofs = dcfd_pkg::OFS_OSC + base;
            default: ofs = dcfd_pkg::OFS_WDT + base;
        endcase
        return ofs;
    endfunction : word_addr

    // Decode of the oscillator and watchdog words
    function automatic dcfd_pkg::dcfd_cfg_t decode(input logic [23:0] osc, input logic [23:0] wdt);
        dcfd_pkg::dcfd_cfg_t c;
        logic [2:0] src;
        logic [1:0] csm;
        logic [1:0] posc;
        logic [1:0] wen;
        c = '0;
        src = osc[dcfd_pkg::OSC_SRC_POS +: 3];
        csm = osc[dcfd_pkg::CSM_POS +: 2];
        posc = osc[dcfd_pkg::POSC_POS +: 2];
        wen = wdt[dcfd_pkg::WATCHDOG_ENABLE_MODE_POS +: 2];
        case (src)
            dcfd_pkg::SRC_FRC_DIVN: c.start_clk = dcfd_pkg::CLK_FRC_DIVN;
            dcfd_pkg::SRC_FRC_DIV16: c.start_clk = dcfd_pkg::CLK_FRC_DIV16;
            dcfd_pkg::SRC_LOW_POWER_RC_OSC: c.start_clk = dcfd_pkg::CLK_LOW_POWER_RC_OSC;
            dcfd_pkg::SRC_PRI_PLL: c.start_clk = dcfd_pkg::CLK_PRI_PLL;
            dcfd_pkg::SRC_FRC_PLL: c.start_clk = dcfd_pkg::CLK_FRC_PLL;
            dcfd_pkg::SRC_FRC: c.start_clk = dcfd_pkg::CLK_FRC;
            default: c.start_clk = dcfd_pkg::CLK_RESERVED;
        endcase
        c.clk_switch_en = ~csm[1];
        c.fail_safe_en = (csm == 2'h0);
        c.pin_remap_single_shot = osc[dcfd_pkg::REMAP_POS];
        c.prim_osc_off = (posc == dcfd_pkg::POSC_OFF);
        c.high_speed_crystal_mode = (posc == dcfd_pkg::POSC_HS);
        c.low_speed_crystal_mode = (posc == dcfd_pkg::POSC_XT);
        if (c.high_speed_crystal_mode || c.low_speed_crystal_mode)
        begin
            c.osc_pin_clk_out = 1'b0;
            c.osc_pin_gpio = 1'b0;
        end
        else
        begin
            c.osc_pin_clk_out = osc[dcfd_pkg::OSCIO_POS];
            c.osc_pin_gpio = ~osc[dcfd_pkg::OSCIO_POS];
        end
        c.wdt_sw_ctrl = (wen == dcfd_pkg::WATCHDOG_ENABLE_MODE_SW);
        c.wdt_active_only = (wen == dcfd_pkg::WATCHDOG_ENABLE_MODE_ACTIVE);
        c.wdt_disabled = (wen == dcfd_pkg::WATCHDOG_ENABLE_MODE_OFF);
        c.wdt_window_mode = ~wdt[dcfd_pkg::WATCHDOG_WINDOW_DISABLE_POS];
        c.pll_lock_wait_enable = wdt[dcfd_pkg::PLLK_POS];
        c.wdt_prescale_div = wdt[dcfd_pkg::WPRE_POS] ? dcfd_pkg::WPRE_DIV_HI : dcfd_pkg::WPRE_DIV_LO;
        c.wdt_postscale_div = dcfd_pkg::WPOST_ONE << wdt[dcfd_pkg::WPOST_POS +: 4];
        return c;
    endfunction : decode

    logic loaded;
    logic single_shot;
    logic csm_lockable;
    logic clk_locked;
    logic remap_permit;
    logic [1:0] wen_now;
    logic [31:0] status_word;

    assign loaded = (st_ff.ld == dcfd_pkg::LD_DONE);
    assign single_shot = st_ff.words[dcfd_pkg::W_OSC][dcfd_pkg::REMAP_POS];
    assign csm_lockable = st_ff.words[dcfd_pkg::W_OSC][dcfd_pkg::CSM_POS];
    assign clk_locked = st_ff.clock_config_lock & csm_lockable;
    assign remap_permit = loaded & ~(single_shot & st_ff.remap_done);
    assign wen_now = st_ff.words[dcfd_pkg::W_WDT][dcfd_pkg::WATCHDOG_ENABLE_MODE_POS +: 2];

    always_comb
    begin
        status_word = '0;
        status_word[dcfd_pkg::STAT_LOADED_POS] = loaded;
        status_word[dcfd_pkg::STAT_SWAP_POS] = st_ff.swap_seen;
        status_word[dcfd_pkg::STAT_LOCKED_POS] = clk_locked;
        status_word[dcfd_pkg::STAT_REMAP_POS] = st_ff.remap_done;
        status_word[dcfd_pkg::STAT_PART_POS] = st_ff.part;
    end

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.nvm_rd = 1'b0;
        nxt_st.rdata = '0;

        // Load sequence after reset
        case (st_ff.ld)
            dcfd_pkg::LD_REQ:
            begin
                if (st_ff.idx == dcfd_pkg::W_DEVOPT)
                begin
                    nxt_st.part = active_partition_i;
                    nxt_st.nvm_addr = word_addr(st_ff.idx, active_partition_i);
                end
                else
                begin
                    nxt_st.nvm_addr = word_addr(st_ff.idx, st_ff.part);
                end
                nxt_st.nvm_rd = 1'b1;
                nxt_st.ld = dcfd_pkg::LD_ISSUE;
            end
            dcfd_pkg::LD_ISSUE:
            begin
                nxt_st.ld = dcfd_pkg::LD_CAPT;
            end
            dcfd_pkg::LD_CAPT:
            begin
                nxt_st.words[st_ff.idx] = nvm_data_i;
                if (st_ff.idx == dcfd_pkg::W_WDT)
                begin
                    nxt_st.ld = dcfd_pkg::LD_DONE;
                end
                else
                begin
                    nxt_st.idx = st_ff.idx + 3'h1;
                    nxt_st.ld = dcfd_pkg::LD_REQ;
                end
            end
            dcfd_pkg::LD_DONE:
            begin
                nxt_st.ld = dcfd_pkg::LD_DONE;
            end
            default:
            begin
                nxt_st.ld = dcfd_pkg::LD_REQ;
            end
        endcase

        // Soft swap is noted but never reloads
        if (soft_swap_i && loaded)
        begin
            nxt_st.swap_seen = 1'b1;
        end

        // Remap usage tracking
        if (remap_write_i && remap_permit)
        begin
            nxt_st.remap_done = 1'b1;
        end

        // Register writes; configuration words ignore them
        if (reg_wr_i && reg_addr_i == dcfd_pkg::OFS_CTRL)
        begin
            nxt_st.sw_watchdog_enable = reg_wdata_i[dcfd_pkg::CTRL_SWDT_POS];
            if (!clk_locked)
            begin
                nxt_st.clock_config_lock = reg_wdata_i[dcfd_pkg::CTRL_LOCK_POS];
            end
        end

        // Register reads
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                dcfd_pkg::OFS_DEVOPT: nxt_st.rdata = {8'h00, st_ff.words[dcfd_pkg::W_DEVOPT]};
                dcfd_pkg::OFS_ALTREG: nxt_st.rdata = {8'h00, st_ff.words[dcfd_pkg::W_ALTREG]};
                dcfd_pkg::OFS_BTSEQ: nxt_st.rdata = {8'h00, st_ff.words[dcfd_pkg::W_BTSEQ]};
                dcfd_pkg::OFS_BOOT: nxt_st.rdata = {8'h00, st_ff.words[dcfd_pkg::W_BOOT]};
                dcfd_pkg::OFS_OSC: nxt_st.rdata = {8'h00, st_ff.words[dcfd_pkg::W_OSC]};
                dcfd_pkg::OFS_WDT: nxt_st.rdata = {8'h00, st_ff.words[dcfd_pkg::W_WDT]};
                dcfd_pkg::OFS_CTRL:
                begin
                    nxt_st.rdata[dcfd_pkg::CTRL_SWDT_POS] = st_ff.sw_watchdog_enable;
                    nxt_st.rdata[dcfd_pkg::CTRL_LOCK_POS] = st_ff.clock_config_lock;
                end
                dcfd_pkg::OFS_STAT: nxt_st.rdata = status_word;
                default: nxt_st.rdata = '0;
            endcase
        end

        // Decoded settings and watchdog run level
        if (loaded)
        begin
            nxt_st.cfg = decode(st_ff.words[dcfd_pkg::W_OSC], st_ff.words[dcfd_pkg::W_WDT]);
            case (wen_now)
                dcfd_pkg::WATCHDOG_ENABLE_MODE_SW: nxt_st.wdt_run = st_ff.sw_watchdog_enable;
                dcfd_pkg::WATCHDOG_ENABLE_MODE_ACTIVE: nxt_st.wdt_run = ~sleep_i;
                dcfd_pkg::WATCHDOG_ENABLE_MODE_OFF: nxt_st.wdt_run = 1'b0;
                default: nxt_st.wdt_run = 1'b1;
            endcase
        end
        else
        begin
            nxt_st.cfg = '0;
            nxt_st.wdt_run = 1'b0;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign nvm_rd_o = st_ff.nvm_rd;
    assign nvm_addr_o = st_ff.nvm_addr;
    assign reg_rdata_o = st_ff.rdata;
    assign cfg_o = st_ff.cfg;
    assign cfg_valid_o = loaded;
    assign wdt_run_o = st_ff.wdt_run;
    assign remap_permit_o = remap_permit;
    assign clk_cfg_locked_o = clk_locked;

endmodule : dcfd_top

`default_nettype wire

// [rtl/dcfd_pkg.sv]
`default_nettype none
package dcfd_pkg;

    // Bus and word widths
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CFG_W = 24;
    localparam int unsigned NUM_WORDS = 6;

    // Register byte addresses
    localparam logic [23:0] OFS_DEVOPT = 24'h002BAC;
    localparam logic [23:0] OFS_ALTREG = 24'h002BB0;
    localparam logic [23:0] OFS_BTSEQ = 24'h002BFC;
    localparam logic [23:0] OFS_BOOT = 24'h801000;
    localparam logic [23:0] OFS_OSC = 24'h002BB4;
    localparam logic [23:0] OFS_WDT = 24'h002BB8;
    localparam logic [23:0] OFS_CTRL = 24'h002BC0;
    localparam logic [23:0] OFS_STAT = 24'h002BC4;

    // Load order of the nonvolatile words
    localparam logic [2:0] W_DEVOPT = 3'h0;
    localparam logic [2:0] W_ALTREG = 3'h1;
    localparam logic [2:0] W_BTSEQ = 3'h2;
    localparam logic [2:0] W_BOOT = 3'h3;
    localparam logic [2:0] W_OSC = 3'h4;
    localparam logic [2:0] W_WDT = 3'h5;

    // Oscillator word fields
    localparam int unsigned OSC_SRC_POS = 0;
    localparam int unsigned POSC_POS = 3;
    localparam int unsigned OSCIO_POS = 5;
    localparam int unsigned REMAP_POS = 6;
    localparam int unsigned CSM_POS = 7;

    // Watchdog word fields
    localparam int unsigned WPOST_POS = 0;
    localparam int unsigned WPRE_POS = 4;
    localparam int unsigned PLLK_POS = 5;
    localparam int unsigned WATCHDOG_WINDOW_DISABLE_POS = 6;
    localparam int unsigned WATCHDOG_ENABLE_MODE_POS = 7;

    // Control and status bits
    localparam int unsigned CTRL_SWDT_POS = 0;
    localparam int unsigned CTRL_LOCK_POS = 1;
    localparam int unsigned STAT_LOADED_POS = 0;
    localparam int unsigned STAT_SWAP_POS = 1;
    localparam int unsigned STAT_LOCKED_POS = 2;
    localparam int unsigned STAT_REMAP_POS = 3;
    localparam int unsigned STAT_PART_POS = 4;

    // Field codes
    localparam logic [2:0] SRC_FRC_DIVN = 3'h7;
    localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_LOW_POWER_RC_OSC = 3'h5;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_FRC_PLL = 3'h2;
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [1:0] POSC_OFF = 2'h3;
    localparam logic [1:0] POSC_HS = 2'h2;
    localparam logic [1:0] POSC_XT = 2'h1;
    localparam logic [1:0] WATCHDOG_ENABLE_MODE_SW = 2'h2;
    localparam logic [1:0] WATCHDOG_ENABLE_MODE_ACTIVE = 2'h1;
    localparam logic [1:0] WATCHDOG_ENABLE_MODE_OFF = 2'h0;
    localparam logic [7:0] WPRE_DIV_HI = 8'h80;
    localparam logic [7:0] WPRE_DIV_LO = 8'h20;
    localparam logic [15:0] WPOST_ONE = 16'h0001;

    typedef enum logic [1:0] {
        LD_REQ = 2'b00,
        LD_ISSUE = 2'b01,
        LD_CAPT = 2'b11,
        LD_DONE = 2'b10
    } dcfd_ld_t;

    typedef enum logic [2:0] {
        CLK_FRC = 3'h0,
        CLK_FRC_PLL = 3'h1,
        CLK_PRI_PLL = 3'h2,
        CLK_LOW_POWER_RC_OSC = 3'h3,
        CLK_FRC_DIV16 = 3'h4,
        CLK_FRC_DIVN = 3'h5,
        CLK_RESERVED = 3'h6
    } dcfd_clk_t;

    typedef struct packed {
        dcfd_clk_t start_clk;
        logic clk_switch_en;
        logic fail_safe_en;
        logic pin_remap_single_shot;
        logic osc_pin_clk_out;
        logic osc_pin_gpio;
        logic prim_osc_off;
        logic high_speed_crystal_mode;
        logic low_speed_crystal_mode;
        logic wdt_sw_ctrl;
        logic wdt_active_only;
        logic wdt_disabled;
        logic wdt_window_mode;
        logic pll_lock_wait_enable;
        logic [7:0] wdt_prescale_div;
        logic [15:0] wdt_postscale_div;
    } dcfd_cfg_t;

    typedef struct packed {
        dcfd_ld_t ld;
        logic [2:0] idx;
        logic nvm_rd;
        logic [23:0] nvm_addr;
        logic part;
        logic [NUM_WORDS-1:0][23:0] words;
        logic sw_watchdog_enable;
        logic clock_config_lock;
        logic swap_seen;
        logic remap_done;
        logic wdt_run;
        logic [31:0] rdata;
        dcfd_cfg_t cfg;
    } dcfd_state_t;

endpackage : dcfd_pkg

`default_nettype wire

// [test/dcfd_chk_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module dcfd_chk (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Watched ports
    input wire logic nvm_rd_o,
    input wire logic [23:0] nvm_addr_o,
    input wire logic [23:0] nvm_data_i,
    input wire logic remap_write_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire dcfd_pkg::dcfd_cfg_t cfg_o,
    input wire logic cfg_valid_o,
    input wire logic wdt_run_o,
    input wire logic remap_permit_o,
    input wire logic clk_cfg_locked_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);
    sequence s_osc_max;
        nvm_rd_o && nvm_addr_o[15:0] == 16'h2BB4 ##1 nvm_data_i[2:0] == 3'h7;
    endsequence
    sequence s_post_max;
        nvm_rd_o && nvm_addr_o[15:0] == 16'h2BB8 ##1 nvm_data_i[3:0] == 4'hF;
    endsequence
    a_rd_spacing: assert property (nvm_rd_o |=> !nvm_rd_o [*2])
        else $error("word requests too close");
    a_load_start: assert property ($fell(srst_i) |-> ##[0:2] nvm_rd_o)
        else $error("load did not start");
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data without read");
    a_no_reload: assert property (cfg_valid_o |-> !nvm_rd_o)
        else $error("word fetched after load");
    a_cfg_frozen: assert property (cfg_valid_o && $past(cfg_valid_o) |=> $stable(cfg_o))
        else $error("settings changed after load");
    a_src_decode: assert property (s_osc_max |-> ##[1:12] cfg_o.start_clk == dcfd_pkg::CLK_FRC_DIVN)
        else $error("source 111 decoded wrong");
    a_post_decode: assert property (s_post_max |-> ##[1:8] cfg_o.wdt_postscale_div == 16'h8000)
        else $error("postscale 1111 decoded wrong");
    a_monitor_gate: assert property (cfg_o.fail_safe_en |-> cfg_o.clk_switch_en && !clk_cfg_locked_o)
        else $error("monitor without switching or locked");
    a_remap_once: assert property (cfg_o.pin_remap_single_shot && remap_permit_o && remap_write_i
        |-> ##[1:2] !remap_permit_o)
        else $error("second remap permitted");
    a_xtal_pin: assert property (cfg_o.high_speed_crystal_mode || cfg_o.low_speed_crystal_mode
        |-> !cfg_o.osc_pin_clk_out && !cfg_o.osc_pin_gpio)
        else $error("pin function in crystal mode");
    a_wdt_off: assert property (cfg_o.wdt_disabled && $past(cfg_o.wdt_disabled) |-> !wdt_run_o)
        else $error("disabled watchdog runs");
endmodule : dcfd_chk
bind dcfd_top dcfd_chk u_chk (.clock_i, .srst_i, .nvm_rd_o, .nvm_addr_o, .nvm_data_i, .remap_write_i,
    .reg_rd_i, .reg_rdata_o, .cfg_o, .cfg_valid_o, .wdt_run_o, .remap_permit_o, .clk_cfg_locked_o);
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [23:0] BOFS = 24'h400000;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic nvm_rd_o, cfg_valid_o, wdt_run_o, remap_permit_o, clk_cfg_locked_o;
    logic [23:0] nvm_addr_o;
    logic [23:0] nvm_data_i = 24'h0;
    logic active_partition_i = 1'b0;
    logic soft_swap_i = 1'b0;
    logic sleep_i = 1'b0;
    logic remap_write_i = 1'b0;
    logic [23:0] reg_addr_i = 24'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o, d;
    dcfd_pkg::dcfd_cfg_t cfg_o, ec;
    int miscompares = 0;
    int checks_done = 0;
    int na = 0;
    logic [15:0] lf = 16'h003E;
    logic [23:0] ow [2];
    logic [23:0] ww [2];
    logic [23:0] ofs [6];
    logic ap;
    always #25 clock_i = ~clock_i;
    dcfd_top #(.PART_B_OFS(BOFS)) uut (.clock_i, .srst_i, .nvm_rd_o, .nvm_addr_o, .nvm_data_i,
        .active_partition_i, .soft_swap_i, .sleep_i, .remap_write_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .cfg_o, .cfg_valid_o, .wdt_run_o, .remap_permit_o,
        .clk_cfg_locked_o);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [23:0] ea(input int k, input logic p);
        return ofs[k] + ((p && k != 3) ? BOFS : 24'h0);
    endfunction : ea
    function automatic logic [23:0] nw(input logic [23:0] a);
        for (int p = 0; p < 2; p++)
        begin
            if (a == dcfd_pkg::OFS_OSC + (p ? BOFS : 24'h0)) return ow[p];
            if (a == dcfd_pkg::OFS_WDT + (p ? BOFS : 24'h0)) return ww[p];
        end
        return a ^ 24'hA5C3E1;
    endfunction : nw
    function automatic logic er(input logic [23:0] w, input logic sw, input logic sl);
        return w[8:7] == 2'h3 || (w[8:7] == 2'h2 && sw) || (w[8:7] == 2'h1 && !sl);
    endfunction : er
    function automatic dcfd_pkg::dcfd_cfg_t ex(input logic [23:0] o, input logic [23:0] w);
        dcfd_pkg::dcfd_cfg_t c;
        logic x;
        c = '0;
        case (o[2:0])
            3'h7: c.start_clk = dcfd_pkg::CLK_FRC_DIVN;
            3'h6: c.start_clk = dcfd_pkg::CLK_FRC_DIV16;
            3'h5: c.start_clk = dcfd_pkg::CLK_LOW_POWER_RC_OSC;
            3'h3: c.start_clk = dcfd_pkg::CLK_PRI_PLL;
            3'h2: c.start_clk = dcfd_pkg::CLK_FRC_PLL;
            3'h0: c.start_clk = dcfd_pkg::CLK_FRC;
            default: c.start_clk = dcfd_pkg::CLK_RESERVED;
        endcase
        c.clk_switch_en = !o[8];
        c.fail_safe_en = o[8:7] == 2'h0;
        c.pin_remap_single_shot = o[6];
        x = o[4:3] == 2'h2 || o[4:3] == 2'h1;
        c.osc_pin_clk_out = !x && o[5];
        c.osc_pin_gpio = !x && !o[5];
        c.prim_osc_off = o[4:3] == 2'h3;
        c.high_speed_crystal_mode = o[4:3] == 2'h2;
        c.low_speed_crystal_mode = o[4:3] == 2'h1;
        c.wdt_sw_ctrl = w[8:7] == 2'h2;
        c.wdt_active_only = w[8:7] == 2'h1;
        c.wdt_disabled = w[8:7] == 2'h0;
        c.wdt_window_mode = !w[6];
        c.pll_lock_wait_enable = w[5];
        c.wdt_prescale_div = w[4] ? 8'h80 : 8'h20;
        c.wdt_postscale_div = 16'h0001 << w[3:0];
        return c;
    endfunction : ex
    task automatic final_report();
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
    endtask : wt
    task automatic rd(input logic [23:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        wt(1);
        reg_rd_i <= 1'b0;
        wt(1);
        d = reg_rdata_o;
    endtask : rd
    task automatic wr(input logic [23:0] a, input logic [31:0] v);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        wt(1);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic pulse_and_wait(input bit remap);
        if (remap)
            remap_write_i <= 1'b1;
        else
            soft_swap_i <= 1'b1;
        wt(1);
        remap_write_i <= 1'b0;
        soft_swap_i <= 1'b0;
        wt(3);
    endtask : pulse_and_wait
    // Word source answering one cycle after each request
    always @(posedge clock_i)
    begin
        if (nvm_rd_o === 1'b1)
        begin
            chk("nvm_addr", 40'(ea(na, active_partition_i)), 40'(nvm_addr_o));
            nvm_data_i <= nw(nvm_addr_o);
            na = na + 1;
        end
        else
            nvm_data_i <= ~nvm_data_i;
    end
    initial
    begin
        ofs = '{dcfd_pkg::OFS_DEVOPT, dcfd_pkg::OFS_ALTREG, dcfd_pkg::OFS_BTSEQ, dcfd_pkg::OFS_BOOT,
            dcfd_pkg::OFS_OSC, dcfd_pkg::OFS_WDT};
        wt(1);
        for (int i = 0; i < 16; i++)
        begin
            for (int p = 0; p < 2; p++)
            begin
                lf = lfsr(lfsr(lf));
                ow[p] = {15'h7FFF, lf[5:0], 3'(i)};
                ww[p] = {15'h7FFF, 2'(i), lf[8:6], 4'(i)};
            end
            ap = lf[9];
            active_partition_i <= ap;
            srst_i <= 1'b1;
            na = 0;
            wt(2);
            srst_i <= 1'b0;
            for (int k = 0; cfg_valid_o !== 1'b1; k++)
            begin
                wt(1);
                if (k > 60)
                begin
                    miscompares++;
                    final_report();
                end
            end
            wt(2);
            ec = ex(ow[ap], ww[ap]);
            chk("cfg", 40'(ec), 40'(cfg_o));
            for (int r = 0; r < 6; r++)
            begin
                rd(ofs[r]);
                chk("word", 40'(nw(ea(r, ap))), 40'(d));
                wr(ofs[r], ~d);
                rd(ofs[r]);
                chk("word kept", 40'(nw(ea(r, ap))), 40'(d));
            end
            rd(24'h002BBC);
            chk("unmapped", 40'h0, 40'(d));
            sleep_i <= lf[11] && ww[ap][8:7] == 2'h1;
            wr(dcfd_pkg::OFS_CTRL, {30'h0, 1'b1, lf[10]});
            wt(3);
            chk("lock", 40'(ow[ap][7]), 40'(clk_cfg_locked_o));
            chk("wdt_run", 40'(er(ww[ap], lf[10], sleep_i)), 40'(wdt_run_o));
            rd(dcfd_pkg::OFS_CTRL);
            chk("ctrl", 40'({1'b1, lf[10]}), 40'(d));
            wr(dcfd_pkg::OFS_CTRL, 32'h0);
            wt(3);
            chk("lock held", 40'(ow[ap][7]), 40'(clk_cfg_locked_o));
            rd(dcfd_pkg::OFS_CTRL);
            chk("ctrl held", 40'({ow[ap][7], 1'b0}), 40'(d));
            chk("wdt_run", 40'(er(ww[ap], 1'b0, sleep_i)), 40'(wdt_run_o));
            chk("permit", 40'h1, 40'(remap_permit_o));
            pulse_and_wait(1'b1);
            chk("permit", 40'(!ow[ap][6]), 40'(remap_permit_o));
            active_partition_i <= !ap;
            pulse_and_wait(1'b0);
            wt(6);
            chk("swap cfg", 40'(ec), 40'(cfg_o));
            rd(dcfd_pkg::OFS_STAT);
            chk("swap seen", 40'h1, 40'(d[1]));
            chk("loaded", 40'h1, 40'(d[0]));
            chk("stat lock", 40'(ow[ap][7]), 40'(d[2]));
            chk("remap done", 40'h1, 40'(d[3]));
            chk("partition", 40'(ap), 40'(d[4]));
        end
        final_report();
    end
endmodule : tb
`default_nettype wire
